// ==== dss_pkg.sv ====
// constants for the dual input source selector
package dss_pkg;
    // register map
    localparam logic [7:0] DSS_CTRL_ADDR  = 8'h0f;  // input_gate_drive_control
    localparam int         DSS_BIT_DRV2   = 0;      // drive2_on_bit
    localparam int         DSS_BIT_DRV1   = 1;      // drive1_on_bit
    localparam int         DSS_BIT_DIS    = 2;      // disable_both_drives
    localparam int         DSS_BIT_FIT1   = 3;      // pair1_fitted_status, read only
    localparam int         DSS_BIT_FIT2   = 4;      // pair2_fitted_status, read only
    localparam int         DSS_BIT_HIZ    = 5;      // high_impedance_enable
    localparam int         DSS_BIT_OTG    = 6;      // reverse_power_enable
    // reset values and drive field values
    localparam logic       DSS_DIS_RST    = 1'b1;
    localparam logic       DSS_HIZ_RST    = 1'b0;
    localparam logic       DSS_OTG_RST    = 1'b0;
    localparam logic [1:0] DSS_SWAP_TO2   = 2'h1;   // field value 01b
    localparam logic [1:0] DSS_SWAP_TO1   = 2'h2;   // field value 10b
    localparam logic [1:0] DSS_BOTH_OFF   = 2'h0;   // field value 00b

    // source selection states
    typedef enum logic [2:0] {
        SEL_OFF = 3'b001,
        SEL_ON1 = 3'b010,
        SEL_ON2 = 3'b100
    } dss_sel_e;
endpackage : dss_pkg

// ==== dss_selector.sv ====
// dual input source selector: gate drive control and its control register
`timescale 1ns/1ns

// Function
// - at power-on, sense grounded drive pins and record whether each pair is fitted.
// - normal mode drive on needs fitted, valid input, no disable, no hiz, bus low.
// - no pairs fitted: drive bits 0, disable-both reads 1, fitted bits 0.
// - disable-both set forces input 1 off; cleared lets it turn on.
// - high-impedance set forces fitted drives off; cleared lets them on again.
// - both fitted and disable-both set: both drives off, both bits 0.
// - both inputs valid together: input 1 wins, input 2 held off.
// - only pair 1 fitted: host write of 0 to drive 1 bit ignored.
// - input 1 falling below threshold turns its drive off automatically.
// - input 1 gone, input 2 valid: input 2 turns on after bus drops.
// - host write 10b to 01b: input 1 off first, input 2 after bus low.
// - outside reverse mode, a host write of 00 to both drive bits is ignored.
// - input 1 invalid while driving: off, then input 2 on after bus low.
// - reverse mode: drives follow host only; over-voltage faults still turn off.
// - setting reverse-power enable sets disable-both automatically.
// - hiz entered on 0 to 1 write, left on 0 write or reset.
// - reverse-mode fault keeps reverse enable; host re-sets drive bits after.
module dss_selector
    import dss_pkg::*;
(
    input  wire logic       clk,                     // core clock, 10 MHz
    input  wire logic       rst_n,                   // power-on reset, active low
    input  wire logic [7:0] reg_addr,                // register address
    input  wire logic       reg_wr,                  // register write strobe
    input  wire logic [7:0] reg_wdata,               // register write data
    output logic      [7:0] reg_rdata,               // read data, one cycle after address
    input  wire logic       pin1_grounded,           // drive 1 pin sensed shorted to ground
    input  wire logic       pin2_grounded,           // drive 2 pin sensed shorted to ground
    input  wire logic       input1_present,          // input1_sense above present threshold
    input  wire logic       input2_present,          // input2_sense above present threshold
    input  wire logic       input1_overvoltage_fault, // input1_sense above over-voltage
    input  wire logic       input2_overvoltage_fault, // input2_sense above over-voltage
    input  wire logic       bus_below_falling,       // bus_voltage below falling threshold
    input  wire logic       bus_overvoltage_fault,   // bus_voltage over-voltage
    output logic            input1_gate_drive,       // gate drive for pair 1
    output logic            input2_gate_drive        // gate drive for pair 2
);

    logic     por_done_ff;
    logic     fit1_ff;
    logic     fit2_ff;
    logic     dis_ff;
    logic     hiz_ff;
    logic     otg_ff;
    logic     otg_req1_ff;
    logic     otg_req2_ff;
    logic     req_ff;
    logic     req_to2_ff;
    dss_sel_e state_ff;
    logic [7:0] rdata_ff;
    logic     drv1_ff;
    logic     drv2_ff;

    logic     nxt_dis;
    logic     nxt_req;
    logic     nxt_req_to2;
    logic     nxt_otg_req1;
    logic     nxt_otg_req2;
    dss_sel_e nxt_state;
    logic     nxt_drv1;
    logic     nxt_drv2;

    // address match of the control register, shared by write and read paths
    function automatic logic dss_addr_hit(input logic [7:0] addr);
        return addr == DSS_CTRL_ADDR;
    endfunction : dss_addr_hit

    // register write decode
    wire       wr_hit     = reg_wr && dss_addr_hit(reg_addr);
    wire [1:0] wr_field   = {reg_wdata[DSS_BIT_DRV1], reg_wdata[DSS_BIT_DRV2]};
    wire       otg_rise   = wr_hit && reg_wdata[DSS_BIT_OTG] && !otg_ff;
    wire       any_fit    = fit1_ff || fit2_ff;
    wire       both_fit   = fit1_ff && fit2_ff;

    // activation conditions per input, bus level checked at turn-on
    wire ok1 = fit1_ff && input1_present && !input1_overvoltage_fault
               && !dis_ff && !hiz_ff;
    wire ok2 = fit2_ff && input2_present && !input2_overvoltage_fault
               && !dis_ff && !hiz_ff;

    // host swap commands, only meaningful with both pairs fitted
    wire swap_to2 = wr_hit && !otg_ff && both_fit && (wr_field == DSS_SWAP_TO2)
                    && (state_ff == SEL_ON1);
    wire swap_to1 = wr_hit && !otg_ff && both_fit && (wr_field == DSS_SWAP_TO1)
                    && (state_ff == SEL_ON2);

    // reverse mode drives: host bits, cut by over-voltage faults
    wire otg_on1 = otg_req1_ff && fit1_ff && !dis_ff && !hiz_ff
                   && !input1_overvoltage_fault && !bus_overvoltage_fault;
    wire otg_on2 = otg_req2_ff && fit2_ff && !dis_ff && !hiz_ff
                   && !input2_overvoltage_fault && !bus_overvoltage_fault;

    // power-on pair sensing, caught once after reset release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            por_done_ff <= 1'b0;
            fit1_ff     <= 1'b0;
            fit2_ff     <= 1'b0;
        end else if (!por_done_ff) begin
            por_done_ff <= 1'b1;
            fit1_ff     <= !pin1_grounded;
            fit2_ff     <= !pin2_grounded;
        end
    end

    // disable-both next value
    always_comb begin
        nxt_dis = dis_ff;
        if (!por_done_ff) begin
            nxt_dis = pin1_grounded && pin2_grounded;
        end else if (otg_rise) begin
            nxt_dis = 1'b1;
        end else if (wr_hit && any_fit) begin
            nxt_dis = reg_wdata[DSS_BIT_DIS];
        end
    end

    // control bits
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dis_ff <= DSS_DIS_RST;
            hiz_ff <= DSS_HIZ_RST;
            otg_ff <= DSS_OTG_RST;
        end else begin
            dis_ff <= nxt_dis;
            if (wr_hit) begin
                hiz_ff <= reg_wdata[DSS_BIT_HIZ];
                otg_ff <= reg_wdata[DSS_BIT_OTG];
            end
        end
    end

    // reverse mode drive requests: host sets, faults clear
    always_comb begin
        nxt_otg_req1 = otg_req1_ff;
        nxt_otg_req2 = otg_req2_ff;
        if (!otg_ff) begin
            nxt_otg_req1 = 1'b0;
            nxt_otg_req2 = 1'b0;
        end else if (wr_hit) begin
            nxt_otg_req1 = reg_wdata[DSS_BIT_DRV1];
            nxt_otg_req2 = reg_wdata[DSS_BIT_DRV2];
        end
        if (input1_overvoltage_fault || bus_overvoltage_fault) begin
            nxt_otg_req1 = 1'b0;
        end
        if (input2_overvoltage_fault || bus_overvoltage_fault) begin
            nxt_otg_req2 = 1'b0;
        end
    end

    // automatic selection, re-evaluated every clock
    always_comb begin
        nxt_state   = state_ff;
        nxt_req     = req_ff || swap_to2 || swap_to1;
        nxt_req_to2 = swap_to2 ? 1'b1 : (swap_to1 ? 1'b0 : req_to2_ff);
        unique case (state_ff)
            SEL_OFF: begin
                if (bus_below_falling) begin
                    if (req_ff && req_to2_ff && ok2) begin
                        nxt_state = SEL_ON2;
                    end else if (req_ff && !req_to2_ff && ok1) begin
                        nxt_state = SEL_ON1;
                    end else if (ok1) begin
                        nxt_state = SEL_ON1;
                    end else if (ok2) begin
                        nxt_state = SEL_ON2;
                    end
                    nxt_req = 1'b0;
                end
            end
            SEL_ON1: begin
                if (!ok1 || (req_ff && req_to2_ff)) begin
                    nxt_state = SEL_OFF;
                end
            end
            SEL_ON2: begin
                if (!ok2 || (req_ff && !req_to2_ff)) begin
                    nxt_state = SEL_OFF;
                end
            end
        endcase
        if (otg_ff) begin
            nxt_state = SEL_OFF;
            nxt_req   = 1'b0;
        end
    end

    // drive outputs
    assign nxt_drv1 = otg_ff ? otg_on1 : (nxt_state == SEL_ON1);
    assign nxt_drv2 = otg_ff ? otg_on2 : (nxt_state == SEL_ON2);

    // selection state and drives
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff    <= SEL_OFF;
            req_ff      <= 1'b0;
            req_to2_ff  <= 1'b0;
            otg_req1_ff <= 1'b0;
            otg_req2_ff <= 1'b0;
            drv1_ff     <= 1'b0;
            drv2_ff     <= 1'b0;
        end else begin
            state_ff    <= nxt_state;
            req_ff      <= nxt_req;
            req_to2_ff  <= nxt_req_to2;
            otg_req1_ff <= nxt_otg_req1;
            otg_req2_ff <= nxt_otg_req2;
            drv1_ff     <= nxt_drv1;
            drv2_ff     <= nxt_drv2;
        end
    end

    // read data: drive bits mirror the outputs
    wire [7:0] ctrl_view = {1'b0, otg_ff, hiz_ff, fit2_ff, fit1_ff, dis_ff,
                            drv1_ff, drv2_ff};
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= dss_addr_hit(reg_addr) ? ctrl_view : 8'h00;
        end
    end

    assign reg_rdata         = rdata_ff;
    assign input1_gate_drive = drv1_ff;
    assign input2_gate_drive = drv2_ff;

    // checks
    default clocking dss_cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_drive_mutual_excl: assert property (
        (!otg_ff && !$past(otg_ff)) |-> !(input1_gate_drive && input2_gate_drive))
        else $error("both drives on outside reverse mode");
    a_disable_both_off: assert property (
        dis_ff |=> !input1_gate_drive && !input2_gate_drive)
        else $error("drive on while disable-both set");
    a_hiz_forces_off: assert property (
        hiz_ff |=> !input1_gate_drive && !input2_gate_drive)
        else $error("drive on while high impedance");
    a_unfitted_stays_off: assert property (
        !fit1_ff |=> !input1_gate_drive)
        else $error("drive 1 on without fitted pair");
    a_bus_gates_turn_on: assert property (
        (!otg_ff && state_ff == SEL_OFF && !bus_below_falling) |=> state_ff == SEL_OFF)
        else $error("drive turned on with bus high");
    a_input_drop_off: assert property (
        (!otg_ff && !input1_present) |=> !input1_gate_drive)
        else $error("drive 1 stayed on after input dropped");
    a_input1_priority: assert property (
        (!otg_ff && state_ff == SEL_OFF && bus_below_falling && ok1 && !req_ff)
        |=> state_ff == SEL_ON1 && input1_gate_drive)
        else $error("input 1 not given priority");
    a_host_swap_order: assert property (
        swap_to2 |=> ##1 !input1_gate_drive && !input2_gate_drive)
        else $error("swap did not turn input 1 off first");
    a_reverse_sets_dis: assert property (
        otg_rise |=> dis_ff ##1 (!input1_gate_drive && !input2_gate_drive))
        else $error("reverse enable did not set disable-both");
    a_reverse_bus_fault: assert property (
        (otg_ff && bus_overvoltage_fault) |=> !input1_gate_drive && !input2_gate_drive)
        else $error("drive on during bus over-voltage");
    a_status_mirror: assert property (
        reg_addr == DSS_CTRL_ADDR |=>
        reg_rdata[DSS_BIT_DRV1] == $past(input1_gate_drive)
        && reg_rdata[DSS_BIT_FIT2] == $past(fit2_ff))
        else $error("status bits do not mirror drives");
    a_unfitted2_off: assert property (
        !fit2_ff |=> !input2_gate_drive)
        else $error("drive 2 on without fitted pair");
    a_no_pair_dis: assert property (
        (por_done_ff && !fit1_ff && !fit2_ff) |-> dis_ff)
        else $error("disable-both clear with no pair fitted");
    a_fit_capture: assert property (
        !por_done_ff |=> fit1_ff == !$past(pin1_grounded) && fit2_ff == !$past(pin2_grounded))
        else $error("fitted status not captured from drive pins");
    a_reverse_host_only: assert property (
        (otg_ff && !otg_req1_ff) |=> !input1_gate_drive)
        else $error("drive 1 on in reverse mode without host request");
    a_reverse_ov2_off: assert property (
        (otg_ff && input2_overvoltage_fault) |=> !input2_gate_drive)
        else $error("drive 2 on during input 2 over-voltage");
    a_swap_back_order: assert property (
        swap_to1 |=> ##1 !input1_gate_drive && !input2_gate_drive)
        else $error("swap back did not turn input 2 off first");

    c_auto_swap: cover property (
        state_ff == SEL_ON1 && !input1_present ##[1:40] state_ff == SEL_ON2);
    c_host_swap: cover property (swap_to2 ##[1:40] input2_gate_drive);
    c_host_swap_back: cover property (swap_to1 ##[1:40] input1_gate_drive);
    c_reverse_drive: cover property (otg_ff && input1_gate_drive);
    c_both_valid: cover property (state_ff == SEL_OFF && ok1 && ok2 && bus_below_falling);

endmodule : dss_selector

// ==== dss_fet_model.sv ====
// behavioural model of the external mosfet pairs and the shared bus node
`timescale 1ns/1ns
module dss_fet_model
    import dss_pkg::*;
(
    input  wire logic       clk,               // core clock
    input  wire logic       rst_n,             // reset, active low
    input  wire logic       fit1,              // pair 1 fitted on the board
    input  wire logic       fit2,              // pair 2 fitted on the board
    input  wire logic [7:0] decay,             // bus bleed time in cycles
    input  wire logic       input1_gate_drive, // gate drive of pair 1
    input  wire logic       input2_gate_drive, // gate drive of pair 2
    output logic            pin1_grounded,     // drive pin 1 strapped low
    output logic            pin2_grounded,     // drive pin 2 strapped low
    output logic            bus_below_falling  // bus node discharged
);
    logic [7:0] cnt_ff;

    // an unfitted pair has its drive pin shorted to ground
    assign pin1_grounded = !fit1;
    assign pin2_grounded = !fit2;

    // bus stays charged while a pair conducts, then bleeds off slowly
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= 8'h00;
        end else if ((input1_gate_drive && fit1) || (input2_gate_drive && fit2)) begin
            cnt_ff <= decay;
        end else if (cnt_ff != 8'h00) begin
            cnt_ff <= cnt_ff - 8'h01;
        end
    end
    assign bus_below_falling = (cnt_ff == 8'h00);
endmodule : dss_fet_model

// ==== testbench.sv ====
// self-checking bench for the dual input source selector
`timescale 1ns/1ns
module testbench
    import dss_pkg::*;
;
    logic       clk, rst_n, reg_wr, fit1, fit2, in1, in2, ov1, ov2, bov;
    logic       p1g, p2g, bus_low, d1, d2, req, chk;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, decay;
    logic [8:0] e;
    logic [8:0] expq[$];
    int         err_total, n_tests;

    dss_selector dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pin1_grounded(p1g),
        .pin2_grounded(p2g), .input1_present(in1), .input2_present(in2),
        .input1_overvoltage_fault(ov1), .input2_overvoltage_fault(ov2),
        .bus_below_falling(bus_low), .bus_overvoltage_fault(bov),
        .input1_gate_drive(d1), .input2_gate_drive(d2));
    dss_fet_model fets (.clk(clk), .rst_n(rst_n), .fit1(fit1), .fit2(fit2), .decay(decay),
        .input1_gate_drive(d1), .input2_gate_drive(d2), .pin1_grounded(p1g),
        .pin2_grounded(p2g), .bus_below_falling(bus_low));

    // clock of 100 ns period
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task results;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results

    task chk_reg(input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: register read %h expected %h", $time, got, exp);
        end
    endtask : chk_reg

    task chk_drv(input logic [1:0] exp, input logic [1:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: drives %h expected %h", $time, got, exp);
        end
    endtask : chk_drv

    // monitor: one cycle after a note, compare the oldest expectation
    always @(posedge clk) chk <= req;
    always @(negedge clk) begin
        if (chk === 1'b1) begin
            e = expq.pop_front();
            if (e[8]) chk_drv(e[1:0], {d1, d2});
            else chk_reg(e[7:0], reg_rdata);
        end
    end

    // present an address and note what the monitor should see
    task note(input logic [8:0] x, input logic [7:0] a);
        @(negedge clk);
        reg_addr = a;
        expq.push_back(x);
        req = 1'b1;
        @(negedge clk);
        req = 1'b0;
    endtask : note

    task rd(input logic [7:0] v);
        note({1'b0, v}, DSS_CTRL_ADDR);
    endtask : rd

    task rd_un;
        logic [7:0] a;
        a = 8'($urandom);
        if (a == DSS_CTRL_ADDR) a = 8'h00;
        note(9'h000, a);
    endtask : rd_un

    task wr(input logic [7:0] v);
        @(negedge clk);
        reg_addr = DSS_CTRL_ADDR;
        reg_wdata = v;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        repeat (3) @(negedge clk);
    endtask : wr

    // drives after a short settle, before the bus can bleed off
    task off_chk;
        repeat (3) @(negedge clk);
        note(9'h100, DSS_CTRL_ADDR);
    endtask : off_chk

    task wt(input logic [1:0] v);
        int i;
        for (i = 0; i < 200 && {d1, d2} !== v; i++) @(negedge clk);
        if (i == 200) begin
            err_total++;
            results();
        end
        note({7'h40, v}, DSS_CTRL_ADDR);
    endtask : wt

    task rst(input logic f1, input logic f2);
        @(negedge clk);
        rst_n = 1'b0;
        fit1 = f1;
        fit2 = f2;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
    endtask : rst

    initial begin
        #2000000;
        err_total++;
        results();
    end

    initial begin
        {rst_n, reg_wr, req, ov1, ov2, bov, fit1, fit2} = 8'h00;
        {in1, in2} = 2'b11;
        reg_addr = DSS_CTRL_ADDR;
        reg_wdata = 8'h00;
        err_total = 0;
        n_tests = 0;
        void'($urandom(71));
        decay = 8'h10 + 8'($urandom % 16);
        rst(1'b0, 1'b0);
        rd(8'h04);
        wr(8'h00); rd(8'h04);
        wr(8'h20); rd(8'h24);
        wt(2'b00);
        repeat (4) rd_un();
        rst(1'b1, 1'b0);
        wt(2'b10); rd(8'h0a);
        wr(8'h00); rd(8'h0a);
        wr(8'h04); rd(8'h0c);
        wr(8'h00); wt(2'b10);
        wr(8'h20); rd(8'h28);
        wr(8'h00); wt(2'b10);
        in1 = 1'b0; off_chk();
        in1 = 1'b1;
        rst(1'b1, 1'b1);
        wt(2'b10); rd(8'h1a);
        wr(8'h03);
        rd(8'h1a);
        wr(8'h01); note(9'h100, DSS_CTRL_ADDR);
        wt(2'b01); rd(8'h19);
        wr(8'h00); rd(8'h19);
        wr(8'h02); wt(2'b10);
        ov1 = 1'b1; off_chk();
        wt(2'b01);
        ov1 = 1'b0;
        wr(8'h04); rd(8'h1c);
        wr(8'h00); wt(2'b10);
        in1 = 1'b0; off_chk();
        wt(2'b01);
        in1 = 1'b1;
        wr(8'h40); rd(8'h5c);
        {in1, in2} = 2'b00;
        wr(8'h40); wr(8'h42); wt(2'b10);
        rd(8'h5a);
        bov = 1'b1; off_chk();
        rd(8'h58);
        bov = 1'b0; off_chk();
        wr(8'h42); wt(2'b10);
        wr(8'h41);
        wt(2'b01);
        ov2 = 1'b1;
        off_chk();
        ov2 = 1'b0;
        rd(8'h58);
        results();
    end
endmodule : testbench
